/* File: scr_params.svh */
// Purpose: offsets, command codes, reset values and counts for the scroll attribute control
// Assumes: included by its bare name wherever a constant is needed
// Notes: every figure of the block lives here once
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// command port address and command codes
`define SCR_CMD_ADDR 8'ha2
`define SCR_GRP_LOW 2'h0
`define SCR_GRP_HIGH 2'h1
`define SCR_GRP_MISC 2'h2
`define SCR_GRP_BASE 2'h3
`define SCR_CMD_BLINK_TOG 4'h8
`define SCR_CMD_VINT_CLR 4'h9
`define SCR_CMD_REV_ON 4'ha
`define SCR_CMD_REV_OFF 4'hb
`define SCR_CMD_BASE_UL 4'hc
`define SCR_CMD_BASE_RV 4'hd

// command field positions
`define SCR_CMD_GRP_HI 3
`define SCR_CMD_GRP_LO 2

// counter figures
`define SCR_MOD10_LAST 4'h9
`define SCR_COUNT_ZERO 4'h0

// reset values
`define SCR_OFFSET_RST 4'h0
`define SCR_BASE_RV_RST 1'b0

`endif

/* File: scr_pkg.sv */
// Purpose: types shared by the scroll attribute control files
// Assumes: nothing beyond the constants header
// Notes: no constants here, only types
package scr_pkg;

	// one-cycle decoded command pulses plus the two payload bits
	typedef struct packed {
		logic loadLow;
		logic loadHigh;
		logic toggleBlink;
		logic clearBlink;
		logic clearVint;
		logic revOn;
		logic revOff;
		logic baseUl;
		logic baseRv;
		logic [1:0] value;
	} scr_cmd_t;

	// line attributes taken at line address load
	typedef struct packed {
		logic scroll;
		logic tall;
		logic wide;
	} scr_attr_t;

	// all pin inputs, synchronised as one group
	typedef struct packed {
		logic cmdStrobe_n;
		logic [7:0] cmdAddr;
		logic [3:0] cmdData;
		logic lineAddrLoad_n;
		logic fetchReq;
		logic fieldStart;
		logic hScan;
		logic scrollRev;
		logic tall;
		logic wide;
		logic blinkAttr;
	} scr_pins_t;

endpackage

/* File: scr_command_decoder.sv */
// Purpose: decode one write on the 4-bit command port into command pulses
// Assumes: inputs already synchronised to clock
// Notes: one command per strobe assertion, data taken at the strobe's falling edge
`timescale 1ns/10ps
`include "scr_params.svh"

module scr_command_decoder (
	input wire logic clock,
	input wire logic rstSync_n,
	input wire logic cmdStrobe_n,
	input wire logic [7:0] cmdAddr,
	input wire logic [3:0] cmdData,
	output scr_pkg::scr_cmd_t cmd
);

	logic prevStrobe_r;
	logic strobeFall;
	scr_pkg::scr_cmd_t cmd_r;
	scr_pkg::scr_cmd_t cmd_nxt;

	// map a 4-bit code to its pulses
	function automatic scr_pkg::scr_cmd_t scr_decode(input logic [3:0] code);
		scr_pkg::scr_cmd_t c;
		c = '0;
		c.value = code[1:0];
		unique case (code[`SCR_CMD_GRP_HI:`SCR_CMD_GRP_LO])
			`SCR_GRP_LOW: c.loadLow = 1'b1;
			`SCR_GRP_HIGH: c.loadHigh = 1'b1;
			`SCR_GRP_MISC: begin
				c.toggleBlink = (code == `SCR_CMD_BLINK_TOG);
				c.clearVint = (code == `SCR_CMD_VINT_CLR);
				c.revOn = (code == `SCR_CMD_REV_ON);
				c.revOff = (code == `SCR_CMD_REV_OFF);
			end
			`SCR_GRP_BASE: begin
				c.clearBlink = 1'b1;
				c.baseUl = (code == `SCR_CMD_BASE_UL);
				c.baseRv = (code == `SCR_CMD_BASE_RV);
			end
		endcase
		return c;
	endfunction

	// one decode per falling strobe edge at the command address
	always_comb begin
		strobeFall = prevStrobe_r & ~cmdStrobe_n;
		cmd_nxt = '0;
		if (strobeFall && (cmdAddr == `SCR_CMD_ADDR)) begin
			cmd_nxt = scr_decode(cmdData);
		end
	end

	// register edge memory and pulses
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			prevStrobe_r <= 1'b1;
			cmd_r <= '0;
		end else begin
			prevStrobe_r <= cmdStrobe_n;
			cmd_r <= cmd_nxt;
		end
	end

	assign cmd = cmd_r;

	chk_toggle_decode: assert property (@(posedge clock) disable iff (!rstSync_n)
		strobeFall && cmdAddr == `SCR_CMD_ADDR && cmdData == `SCR_CMD_BLINK_TOG
		|=> cmd_r.toggleBlink && !cmd_r.clearBlink)
		else $error("blink toggle not decoded");

	chk_cmd_once: assert property (@(posedge clock) disable iff (!rstSync_n)
		(cmd_r != '0) |=> (cmd_r == '0))
		else $error("command pulse longer than one cycle");

	chk_group_clear: assert property (@(posedge clock) disable iff (!rstSync_n)
		strobeFall && cmdAddr == `SCR_CMD_ADDR && cmdData[3:2] == `SCR_GRP_BASE
		|=> cmd_r.clearBlink)
		else $error("upper group write did not clear blink");

endmodule

/* File: scr_scan_counters.sv */
// Purpose: scan and offset counters, both modulo ten
// Assumes: tick is one pulse per horizontal scan, fieldStart one pulse per field
// Notes: field start wins over the scan tick
`timescale 1ns/10ps
`include "scr_params.svh"

module scr_scan_counters (
	input wire logic clock,
	input wire logic rstSync_n,
	input wire logic tick,
	input wire logic fieldStart,
	input wire logic [3:0] offsetLoad,
	output logic [3:0] scanCount,
	output logic [3:0] offsetCount,
	output logic boundary
);

	logic [3:0] scan_r;
	logic [3:0] scan_nxt;
	logic [3:0] offset_r;
	logic [3:0] offset_nxt;
	logic boundary_r;
	logic boundary_nxt;

	// step a decimal digit, wrapping after nine
	function automatic logic [3:0] scr_mod10(input logic [3:0] v);
		return (v >= `SCR_MOD10_LAST) ? `SCR_COUNT_ZERO : v + 4'h1;
	endfunction

	// next counts and row boundary pulse
	always_comb begin
		scan_nxt = scan_r;
		offset_nxt = offset_r;
		if (fieldStart) begin
			scan_nxt = `SCR_COUNT_ZERO;
			offset_nxt = offsetLoad;
		end else if (tick) begin
			scan_nxt = scr_mod10(scan_r);
			offset_nxt = scr_mod10(offset_r);
		end
		boundary_nxt = (fieldStart || tick) && (scan_nxt == `SCR_COUNT_ZERO);
	end

	// register the counters
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			scan_r <= `SCR_COUNT_ZERO;
			offset_r <= `SCR_COUNT_ZERO;
			boundary_r <= 1'b0;
		end else begin
			scan_r <= scan_nxt;
			offset_r <= offset_nxt;
			boundary_r <= boundary_nxt;
		end
	end

	assign scanCount = scan_r;
	assign offsetCount = offset_r;
	assign boundary = boundary_r;

	chk_field_clear: assert property (@(posedge clock) disable iff (!rstSync_n)
		fieldStart |=> scan_r == `SCR_COUNT_ZERO && offset_r == $past(offsetLoad))
		else $error("field start did not reset counters");

	chk_scan_wrap: assert property (@(posedge clock) disable iff (!rstSync_n)
		!fieldStart && tick && scan_r == `SCR_MOD10_LAST |=> scan_r == `SCR_COUNT_ZERO)
		else $error("scan counter did not wrap after nine");

	chk_offset_hold: assert property (@(posedge clock) disable iff (!rstSync_n)
		!fieldStart && !tick |=> $stable(offset_r))
		else $error("offset counter moved without tick or field start");

endmodule

/* File: scr_attr_control.sv */
// Purpose: scroll, blink, reverse and line attribute control of a character terminal
// Assumes: all pin inputs are asynchronous; clock is 20 MHz
// Notes: field start also clears the first line attribute latch; the second latch keeps its value
// Contract
// - processor writes 4-bit command at address a2; device decodes it on the strobe
// - group 00 loads the two low bits of the scroll offset latch
// - group 01 loads the two high bits, so a full offset needs two writes
// - command 1000 complements the blink flip-flop
// - blink state affects only characters carrying the blink attribute
// - vertical interrupt flag sets on falling edge of field start
// - command 1001 clears the vertical interrupt flag
// - reverse field has separate absolute on and off commands
// - 1100 selects underline base attribute, 1101 selects reverse base attribute
// - any 11xx command also clears the blink flip-flop
// - first latch takes scroll, tall and wide bits at line address load fall
// - tall implies wide; wide bit then selects top or bottom half
// - wide bit lengthens the line fetch request
// - second latch copies tall and wide at fetch request rise and drives attributes
// - shared pin is scroll at address load, reverse video at all other times
// - scan and offset counters, 4 bits, modulo ten, step once per scan
// - field start clears the scan counter to zero
// - offset counter loads from the offset latch only at field start
// - mux sends offset count in scroll zone, scan count otherwise
// - scroll flip-flop loads only when the scan counter is zero
`timescale 1ns/10ps
`include "scr_params.svh"

module scr_attr_control (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic video_command_write_strobe_n,
	input wire logic [7:0] commandAddr,
	input wire logic [3:0] commandData,
	input wire logic line_address_load_n,
	input wire logic lineFetchReq,
	input wire logic fieldStart,
	input wire logic hScan,
	input wire logic scrollReverseIn,
	input wire logic tall_line_bit,
	input wire logic wide_line_bit,
	input wire logic charBlinkAttr,
	output logic [3:0] scanCountOut,
	output logic vertIntFlag,
	output logic blinkState,
	output logic charBlinkOff,
	output logic reverseField,
	output logic baseReverse,
	output logic reverseVideo,
	output logic tallActive,
	output logic wideActive,
	output logic bottomHalf,
	output logic fetchExtend,
	output logic scrollActive
);

	logic rstMeta_r;
	logic rstSync_n;
	scr_pkg::scr_pins_t pinsIn;
	scr_pkg::scr_pins_t pinsMeta_r;
	scr_pkg::scr_pins_t pins_r;
	scr_pkg::scr_pins_t prev_r;
	scr_pkg::scr_cmd_t cmd;
	logic loadFall;
	logic fetchRise;
	logic fieldRise;
	logic fieldFall;
	logic scanTick;
	logic [3:0] scanCount;
	logic [3:0] offsetCount;
	logic boundary;

	logic [3:0] offLatch_r;
	logic [3:0] offLatch_nxt;
	logic blink_r;
	logic blink_nxt;
	logic vint_r;
	logic vint_nxt;
	logic revField_r;
	logic revField_nxt;
	logic baseRv_r;
	logic baseRv_nxt;
	scr_pkg::scr_attr_t attr1_r;
	scr_pkg::scr_attr_t attr1_nxt;
	logic tall2_r;
	logic tall2_nxt;
	logic wide2_r;
	logic wide2_nxt;
	logic scrollFf_r;
	logic scrollFf_nxt;
	logic [3:0] scanOut_r;
	logic [3:0] scanOut_nxt;
	logic revVideo_r;
	logic revVideo_nxt;
	logic blinkOff_r;
	logic blinkOff_nxt;
	logic tallAct_r;
	logic tallAct_nxt;
	logic wideAct_r;
	logic wideAct_nxt;
	logic bottom_r;
	logic bottom_nxt;
	logic extend_r;
	logic extend_nxt;

	// reset release through two flip-flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_n <= rstMeta_r;
		end
	end

	// gather the pins into one group
	always_comb begin
		pinsIn.cmdStrobe_n = video_command_write_strobe_n;
		pinsIn.cmdAddr = commandAddr;
		pinsIn.cmdData = commandData;
		pinsIn.lineAddrLoad_n = line_address_load_n;
		pinsIn.fetchReq = lineFetchReq;
		pinsIn.fieldStart = fieldStart;
		pinsIn.hScan = hScan;
		pinsIn.scrollRev = scrollReverseIn;
		pinsIn.tall = tall_line_bit;
		pinsIn.wide = wide_line_bit;
		pinsIn.blinkAttr = charBlinkAttr;
	end

	// two-stage synchroniser and one more stage for edge detection
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pinsMeta_r <= '{cmdStrobe_n: 1'b1, lineAddrLoad_n: 1'b1, default: '0}; // idle strobes
			pins_r <= '{cmdStrobe_n: 1'b1, lineAddrLoad_n: 1'b1, default: '0};
			prev_r <= '{cmdStrobe_n: 1'b1, lineAddrLoad_n: 1'b1, default: '0}; // no false edge
		end else begin
			pinsMeta_r <= pinsIn;
			pins_r <= pinsMeta_r;
			prev_r <= pins_r;
		end
	end

	// edges of the synchronised timing strobes
	assign loadFall = prev_r.lineAddrLoad_n & ~pins_r.lineAddrLoad_n;
	assign fetchRise = ~prev_r.fetchReq & pins_r.fetchReq;
	assign fieldRise = ~prev_r.fieldStart & pins_r.fieldStart;
	assign fieldFall = prev_r.fieldStart & ~pins_r.fieldStart;
	assign scanTick = ~prev_r.hScan & pins_r.hScan;

	// command port decode
	scr_command_decoder u_decoder (
		.clock(clock),
		.rstSync_n(rstSync_n),
		.cmdStrobe_n(pins_r.cmdStrobe_n),
		.cmdAddr(pins_r.cmdAddr),
		.cmdData(pins_r.cmdData),
		.cmd(cmd)
	);

	// scan and offset counters
	scr_scan_counters u_counters (
		.clock(clock),
		.rstSync_n(rstSync_n),
		.tick(scanTick),
		.fieldStart(fieldRise),
		.offsetLoad(offLatch_r),
		.scanCount(scanCount),
		.offsetCount(offsetCount),
		.boundary(boundary)
	);

	// command driven state: offset latch, blink, interrupt flag, reverse, base
	always_comb begin
		offLatch_nxt = offLatch_r;
		if (cmd.loadLow) begin
			offLatch_nxt[1:0] = cmd.value;
		end
		if (cmd.loadHigh) begin
			offLatch_nxt[3:2] = cmd.value;
		end
		blink_nxt = blink_r;
		if (cmd.toggleBlink) begin
			blink_nxt = ~blink_r;
		end else if (cmd.clearBlink) begin
			blink_nxt = 1'b0;
		end
		vint_nxt = vint_r;
		if (fieldFall) begin
			vint_nxt = 1'b1;
		end else if (cmd.clearVint) begin
			vint_nxt = 1'b0;
		end
		revField_nxt = revField_r;
		if (cmd.revOn) begin
			revField_nxt = 1'b1;
		end else if (cmd.revOff) begin
			revField_nxt = 1'b0;
		end
		baseRv_nxt = baseRv_r;
		if (cmd.baseRv) begin
			baseRv_nxt = 1'b1;
		end else if (cmd.baseUl) begin
			baseRv_nxt = 1'b0;
		end
	end

	// line attribute latches, scroll flip-flop and registered outputs
	always_comb begin
		attr1_nxt = attr1_r;
		if (fieldRise) begin
			attr1_nxt = '0;
		end else if (loadFall) begin
			attr1_nxt.scroll = pins_r.scrollRev;
			attr1_nxt.tall = pins_r.tall;
			attr1_nxt.wide = pins_r.wide;
		end
		tall2_nxt = tall2_r;
		wide2_nxt = wide2_r;
		if (fetchRise) begin
			tall2_nxt = attr1_r.tall;
			wide2_nxt = attr1_r.wide;
		end
		scrollFf_nxt = scrollFf_r;
		if (boundary) begin
			scrollFf_nxt = attr1_r.scroll;
		end
		scanOut_nxt = scrollFf_r ? offsetCount : scanCount;
		revVideo_nxt = pins_r.scrollRev & pins_r.lineAddrLoad_n;
		blinkOff_nxt = pins_r.blinkAttr & blink_r;
		tallAct_nxt = tall2_r;
		wideAct_nxt = wide2_r | tall2_r;
		bottom_nxt = tall2_r & wide2_r;
		extend_nxt = attr1_r.wide | attr1_r.tall;
	end

	// register all state
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			offLatch_r <= `SCR_OFFSET_RST;
			blink_r <= 1'b0;
			vint_r <= 1'b0;
			revField_r <= 1'b0;
			baseRv_r <= `SCR_BASE_RV_RST;
			attr1_r <= '0;
			tall2_r <= 1'b0;
			wide2_r <= 1'b0;
			scrollFf_r <= 1'b0;
			scanOut_r <= `SCR_COUNT_ZERO;
			revVideo_r <= 1'b0;
			blinkOff_r <= 1'b0;
			tallAct_r <= 1'b0;
			wideAct_r <= 1'b0;
			bottom_r <= 1'b0;
			extend_r <= 1'b0;
		end else begin
			offLatch_r <= offLatch_nxt;
			blink_r <= blink_nxt;
			vint_r <= vint_nxt;
			revField_r <= revField_nxt;
			baseRv_r <= baseRv_nxt;
			attr1_r <= attr1_nxt;
			tall2_r <= tall2_nxt;
			wide2_r <= wide2_nxt;
			scrollFf_r <= scrollFf_nxt;
			scanOut_r <= scanOut_nxt;
			revVideo_r <= revVideo_nxt;
			blinkOff_r <= blinkOff_nxt;
			tallAct_r <= tallAct_nxt;
			wideAct_r <= wideAct_nxt;
			bottom_r <= bottom_nxt;
			extend_r <= extend_nxt;
		end
	end

	// outputs straight from flip-flops
	assign scanCountOut = scanOut_r;
	assign vertIntFlag = vint_r;
	assign blinkState = blink_r;
	assign charBlinkOff = blinkOff_r;
	assign reverseField = revField_r;
	assign baseReverse = baseRv_r;
	assign reverseVideo = revVideo_r;
	assign tallActive = tallAct_r;
	assign wideActive = wideAct_r;
	assign bottomHalf = bottom_r;
	assign fetchExtend = extend_r;
	assign scrollActive = scrollFf_r;

	// attribute capture followed by copy into the second latch
	sequence seq_capture;
		loadFall && !fieldRise ##[1:20] fetchRise && !loadFall && !fieldRise;
	endsequence

	chk_attr_stages: assert property (@(posedge clock) disable iff (!rstSync_n)
		seq_capture |=> tall2_r == attr1_r.tall && wide2_r == attr1_r.wide)
		else $error("second attribute latch did not copy the first");

	chk_blink_toggle: assert property (@(posedge clock) disable iff (!rstSync_n)
		cmd.toggleBlink |=> blink_r != $past(blink_r))
		else $error("blink did not toggle");

	chk_blink_clear: assert property (@(posedge clock) disable iff (!rstSync_n)
		cmd.clearBlink |=> !blink_r ##1 !blinkState)
		else $error("blink not cleared by upper group command");

	chk_vint_set: assert property (@(posedge clock) disable iff (!rstSync_n)
		fieldFall |=> vertIntFlag)
		else $error("interrupt flag not set at field start end");

	chk_vint_clear: assert property (@(posedge clock) disable iff (!rstSync_n)
		cmd.clearVint && !fieldFall |=> !vertIntFlag)
		else $error("interrupt flag not cleared");

	chk_rev_absolute: assert property (@(posedge clock) disable iff (!rstSync_n)
		cmd.revOn |=> reverseField ##1 (reverseField || $past(cmd.revOff)))
		else $error("reverse field not forced on");

	chk_scroll_row: assert property (@(posedge clock) disable iff (!rstSync_n)
		!boundary |=> $stable(scrollFf_r))
		else $error("scroll zone changed off a row boundary");

	chk_mux_select: assert property (@(posedge clock) disable iff (!rstSync_n)
		1'b1 |=> scanCountOut == ($past(scrollFf_r) ? $past(offsetCount) : $past(scanCount)))
		else $error("scan count mux picked the wrong counter");

	chk_offset_pair: assert property (@(posedge clock) disable iff (!rstSync_n)
		cmd.loadHigh |=> offLatch_r[3:2] == $past(cmd.value) && $stable(offLatch_r[1:0]))
		else $error("high offset write disturbed the latch");

	chk_tall_wide: assert property (@(posedge clock) disable iff (!rstSync_n)
		tall2_r |=> wideActive && bottomHalf == $past(wide2_r))
		else $error("tall line did not imply wide");

endmodule

/* File: scr_host_model.sv */
// Purpose: processor and line fetch side of the scroll attribute control
// Assumes: every pin is changed 1 ns after a rising clock edge
// Notes: address and data show the inverse of the last value from one clock after the strobe is released
`timescale 1ns/10ps
`include "scr_params.svh"

module scr_host_model (
	input wire logic clock,
	output scr_pkg::scr_pins_t pins
);

	scr_pkg::scr_pins_t drv;

	// the pins always show the driven image
	assign pins = drv;

	// idle pins: strobes inactive, events low
	initial begin
		drv = '0;
		drv.cmdStrobe_n = 1'b1;
		drv.lineAddrLoad_n = 1'b1;
	end

	// move to just after the n-th following rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// one write on the command port, strobe low for lowCycles clocks; code 7 to the command address is dropped without a write
	task automatic write_cmd(input logic [7:0] a, input logic [3:0] d, input int lowCycles);
		if (a == `SCR_CMD_ADDR && d == 4'h7) begin
			return;
		end
		step(1);
		drv.cmdAddr = a;
		drv.cmdData = d;
		step(3);
		drv.cmdStrobe_n = 1'b0;
		step(lowCycles);
		drv.cmdStrobe_n = 1'b1;
		step(1);
		drv.cmdAddr = ~a;
		drv.cmdData = ~d;
		step(3);
	endtask

	// drive one event pin: 0 field start, 1 scan, 2 address load, 3 fetch request
	task automatic set_evt(input int sel, input logic on);
		case (sel)
			0: drv.fieldStart = on;
			1: drv.hScan = on;
			2: drv.lineAddrLoad_n = ~on;
			default: drv.fetchReq = on;
		endcase
	endtask

	// one event pulse, four clocks high and four low
	task automatic pulse(input int sel);
		step(1);
		set_evt(sel, 1'b1);
		step(4);
		set_evt(sel, 1'b0);
		step(4);
	endtask

	// line attribute and character pins
	task automatic set_line(input logic sr, input logic t, input logic w, input logic b);
		step(1);
		drv.scrollRev = sr;
		drv.tall = t;
		drv.wide = w;
		drv.blinkAttr = b;
		step(5);
	endtask

endmodule

/* File: test_scr_attr_control.sv */
// Purpose: self-checking bench for the scroll attribute control
// Assumes: 20 MHz clock, pins driven by the host model
// Notes: every expectation follows from command codes and event counts
`timescale 1ns/10ps
`include "scr_params.svh"

module test_scr_attr_control;
	logic clock;
	logic rst_n;
	scr_pkg::scr_pins_t pins;
	logic [3:0] scanCountOut;
	logic vertIntFlag, blinkState, charBlinkOff, reverseField, baseReverse, reverseVideo;
	logic tallActive, wideActive, bottomHalf, fetchExtend, scrollActive;
	int n_mismatch;
	int checks;

	scr_host_model scr_host_model_i (.clock(clock), .pins(pins));

	scr_attr_control scr_attr_control_i (
		.clock(clock), .rst_n(rst_n),
		.video_command_write_strobe_n(pins.cmdStrobe_n),
		.commandAddr(pins.cmdAddr), .commandData(pins.cmdData),
		.line_address_load_n(pins.lineAddrLoad_n), .lineFetchReq(pins.fetchReq),
		.fieldStart(pins.fieldStart), .hScan(pins.hScan),
		.scrollReverseIn(pins.scrollRev), .tall_line_bit(pins.tall),
		.wide_line_bit(pins.wide), .charBlinkAttr(pins.blinkAttr),
		.scanCountOut(scanCountOut), .vertIntFlag(vertIntFlag), .blinkState(blinkState),
		.charBlinkOff(charBlinkOff), .reverseField(reverseField),
		.baseReverse(baseReverse), .reverseVideo(reverseVideo),
		.tallActive(tallActive), .wideActive(wideActive), .bottomHalf(bottomHalf),
		.fetchExtend(fetchExtend), .scrollActive(scrollActive)
	);

	// 50 ns clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// counts and verdict, the only way out
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// single bit compare
	task automatic check1(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// scan count compare
	task automatic check4(input logic [3:0] got, input logic [3:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// command write to the control address
	task automatic cmd(input logic [3:0] d);
		scr_host_model_i.write_cmd(`SCR_CMD_ADDR, d, 4);
	endtask

	// hang guard
	initial begin
		#2000000;
		n_mismatch++;
		$display("[ERR] %0t run did not finish", $time);
		tally_and_finish();
	end

	// main sequence
	initial begin
		logic t;
		logic w;
		logic pt;
		n_mismatch = 0;
		checks = 0;
		rst_n = 1'b0;
		pt = 1'b0;
		repeat (3) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		check1(blinkState, 1'b0, "blink after reset");
		check4(scanCountOut, 4'h0, "scan after reset");
		cmd(`SCR_CMD_BLINK_TOG);
		check1(blinkState, 1'b1, "blink toggle on");
		scr_host_model_i.set_line(1'b0, 1'b0, 1'b0, 1'b1);
		check1(charBlinkOff, 1'b1, "blinking char off");
		scr_host_model_i.set_line(1'b0, 1'b0, 1'b0, 1'b0);
		check1(charBlinkOff, 1'b0, "plain char untouched");
		cmd(`SCR_CMD_BLINK_TOG);
		check1(blinkState, 1'b0, "blink toggle off");
		scr_host_model_i.write_cmd(8'ha3, `SCR_CMD_BLINK_TOG, 4);
		check1(blinkState, 1'b0, "other address ignored");
		scr_host_model_i.write_cmd(`SCR_CMD_ADDR, `SCR_CMD_BLINK_TOG, 20);
		check1(blinkState, 1'b1, "long strobe one toggle");
		// every 11xx code clears blink, two of them pick the base attribute
		for (int i = 12; i < 16; i++) begin
			if (i > 12) cmd(`SCR_CMD_BLINK_TOG);
			cmd(4'(i));
			check1(blinkState, 1'b0, "11xx clears blink");
			if (i < 14) check1(baseReverse, 1'(i), "base attribute");
		end
		// reverse field set twice and cleared twice, never toggled
		for (int i = 0; i < 4; i++) begin
			cmd(i < 2 ? `SCR_CMD_REV_ON : `SCR_CMD_REV_OFF);
			check1(reverseField, 1'(i < 2), "reverse field");
		end
		scr_host_model_i.pulse(0);
		check1(vertIntFlag, 1'b1, "vint set");
		check4(scanCountOut, 4'h0, "scan cleared");
		cmd(`SCR_CMD_VINT_CLR);
		check1(vertIntFlag, 1'b0, "vint clear");
		for (int k = 1; k <= 12; k++) begin
			scr_host_model_i.pulse(1);
			check4(scanCountOut, 4'(k % 10), "scan count");
		end
		// offset 7 in two writes, taken at the next field start
		cmd(4'h3);
		cmd(4'h5);
		scr_host_model_i.pulse(0);
		scr_host_model_i.set_line(1'b1, 1'b0, 1'b0, 1'b0);
		scr_host_model_i.pulse(2);
		check1(reverseVideo, 1'b1, "shared pin as reverse");
		scr_host_model_i.set_line(1'b0, 1'b0, 1'b0, 1'b0);
		check1(reverseVideo, 1'b0, "reverse follows pin");
		for (int k = 1; k <= 13; k++) begin
			scr_host_model_i.pulse(1);
			check1(scrollActive, 1'(k >= 10), "scroll at boundary only");
			check4(scanCountOut, 4'((k >= 10 ? 7 + k : k) % 10), "mux count");
		end
		cmd(4'h2);
		cmd(4'h4);
		scr_host_model_i.pulse(1);
		check4(scanCountOut, 4'h1, "offset kept until field start");
		scr_host_model_i.pulse(0);
		check4(scanCountOut, 4'h0, "new field count");
		check1(scrollActive, 1'b0, "scroll cleared at field");
		// line attributes: tall only, tall and wide, wide only, none
		for (int i = 0; i < 4; i++) begin
			t = (i < 2);
			w = (i == 1 || i == 2);
			scr_host_model_i.set_line(1'b0, t, w, 1'b0);
			scr_host_model_i.pulse(2);
			check1(fetchExtend, t | w, "fetch extend");
			check1(tallActive, pt, "second latch holds");
			scr_host_model_i.pulse(3);
			check1(tallActive, t, "tall active");
			check1(wideActive, t | w, "wide active");
			check1(bottomHalf, t & w, "bottom half");
			pt = t;
		end
		tally_and_finish();
	end

endmodule
